/* File: rtl/qpd_pkg.sv */
package qpd_pkg;
   // =====================================================
   // geometry
   localparam int QPD_POTS      = 4;
   localparam int QPD_SLOTS     = 4;
   localparam int QPD_WIPER_W   = 6;
   localparam logic [5:0] QPD_WIPER_MAX = 6'h3F;
   localparam logic [5:0] QPD_WIPER_MIN = 6'h00;
   // =====================================================
   // address byte: fixed code, arbitrary value
   localparam logic [3:0] QPD_DEV_CODE = 4'h9;
   // =====================================================
   // opcodes (upper nibble of instruction byte)
   localparam logic [3:0] QPD_OP_RD_WIPER = 4'h9;
   localparam logic [3:0] QPD_OP_WR_WIPER = 4'hA;
   localparam logic [3:0] QPD_OP_RD_SLOT  = 4'hB;
   localparam logic [3:0] QPD_OP_WR_SLOT  = 4'hC;
   localparam logic [3:0] QPD_OP_RECALL1  = 4'hD;
   localparam logic [3:0] QPD_OP_SAVE1    = 4'hE;
   localparam logic [3:0] QPD_OP_RECALL_G = 4'h1;
   localparam logic [3:0] QPD_OP_SAVE_G   = 4'h8;
   localparam logic [3:0] QPD_OP_STEP     = 4'h2;
   // =====================================================
   // timing
   localparam int QPD_CLK_MHZ     = 40;
   localparam int QPD_NV_TIME_US  = 5000;
   localparam int QPD_NV_CYCLES   = QPD_NV_TIME_US * QPD_CLK_MHZ;
   // =====================================================
   // carriers
   typedef enum logic [2:0] {
      QPD_CMD_NONE   = 3'h0,
      QPD_CMD_WR_WIP = 3'h1,
      QPD_CMD_WR_SLT = 3'h2,
      QPD_CMD_RCL    = 3'h3,
      QPD_CMD_SAVE   = 3'h4,
      QPD_CMD_STEP   = 3'h5
   } qpd_cmd_t;
   typedef struct packed {
      qpd_cmd_t   cmd;
      logic       all_pots;
      logic [1:0] pot;
      logic [1:0] slot;
      logic [5:0] data;
   } qpd_req_t;
endpackage

/* File: rtl/qpd_link.sv */
`timescale 1ns/1ps
// =====================================================
// bit-level link logic on the bus clock
module qpd_link
   import qpd_pkg::*;
(
   input  wire logic        scl_in,
   input  wire logic        rst_b_in,
   input  wire logic        sda_in,
   input  wire logic [3:0]  strap_addr_in,
   input  wire logic [5:0]  rd_data_in,
   output logic             sda_oe_out,
   output logic [1:0]       rd_pot_out,
   output logic [1:0]       rd_slot_out,
   output logic             rd_slot_sel_out,
   output qpd_req_t         req_out,
   output logic             req_tgl_out,
   output logic             stop_tgl_out
);
   typedef enum logic [2:0] {
      QPD_L_IDLE  = 3'h0,
      QPD_L_ADDR  = 3'h1,
      QPD_L_INSTR = 3'h3,
      QPD_L_DATA  = 3'h2,
      QPD_L_READ  = 3'h6,
      QPD_L_STEP  = 3'h7,
      QPD_L_SKIP  = 3'h5
   } qpd_lstate_t;

   qpd_lstate_t state;
   logic [2:0]  bit_cnt;
   logic [7:0]  shreg;
   logic [3:0]  opcode;
   logic        ack_pend;
   logic        start_tgl;
   logic        start_seen;
   logic        start_ack;
   logic [7:0]  byte_now;
   logic [7:0]  tx_byte;

   assign byte_now = {shreg[6:0], sda_in};
   assign tx_byte  = {2'b00, rd_data_in};

   // start and stop: sda edges while scl high
   always_ff @(negedge sda_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         start_tgl <= 1'b0;
      end else if (scl_in) begin
         start_tgl <= ~start_tgl;
      end
   end

   always_ff @(posedge sda_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         stop_tgl_out <= 1'b0;
      end else if (scl_in) begin
         stop_tgl_out <= ~stop_tgl_out;
      end
   end

   assign start_seen = start_tgl ^ start_ack;

   // receive on rising scl
   always_ff @(posedge scl_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state       <= QPD_L_IDLE;
         bit_cnt     <= 3'h0;
         shreg       <= 8'h00;
         opcode      <= 4'h0;
         ack_pend    <= 1'b0;
         start_ack   <= 1'b0;
         rd_pot_out  <= 2'h0;
         rd_slot_out <= 2'h0;
         rd_slot_sel_out <= 1'b0;
         req_out     <= '0;
         req_tgl_out <= 1'b0;
      end else if (start_seen) begin
         start_ack <= start_tgl;
         state     <= QPD_L_ADDR;
         bit_cnt   <= 3'h1;
         shreg     <= {7'h00, sda_in};
         ack_pend  <= 1'b0;
      end else if (ack_pend) begin
         ack_pend <= 1'b0;
         bit_cnt  <= 3'h0;
         if (state == QPD_L_READ && bit_cnt != 3'h0) begin
            state <= QPD_L_SKIP; // host ack ends read byte
         end
      end else begin
         case (state)
            QPD_L_ADDR: begin
               shreg   <= byte_now;
               bit_cnt <= bit_cnt + 3'h1;
               if (bit_cnt == 3'h7) begin
                  if (byte_now == {QPD_DEV_CODE, strap_addr_in}) begin
                     state    <= QPD_L_INSTR;
                     ack_pend <= 1'b1;
                  end else begin
                     state <= QPD_L_SKIP;
                  end
               end
            end
            QPD_L_INSTR: begin
               shreg   <= byte_now;
               bit_cnt <= bit_cnt + 3'h1;
               if (bit_cnt == 3'h7) begin
                  opcode      <= byte_now[7:4];
                  rd_pot_out  <= byte_now[3:2];
                  rd_slot_out <= byte_now[1:0];
                  req_out.pot  <= byte_now[3:2];
                  req_out.slot <= byte_now[1:0];
                  req_out.all_pots <= 1'b0;
                  ack_pend    <= 1'b1;
                  state       <= QPD_L_SKIP;
                  case (byte_now[7:4])
                     QPD_OP_RD_WIPER: begin
                        rd_slot_sel_out <= 1'b0;
                        state <= QPD_L_READ;
                     end
                     QPD_OP_RD_SLOT: begin
                        rd_slot_sel_out <= 1'b1;
                        state <= QPD_L_READ;
                     end
                     QPD_OP_WR_WIPER, QPD_OP_WR_SLOT: begin
                        state <= QPD_L_DATA;
                     end
                     QPD_OP_STEP: begin
                        state <= QPD_L_STEP;
                     end
                     QPD_OP_RECALL_G, QPD_OP_SAVE_G,
                     QPD_OP_RECALL1, QPD_OP_SAVE1: begin
                        req_out.all_pots <= (byte_now[7:4] == QPD_OP_RECALL_G)
                           || (byte_now[7:4] == QPD_OP_SAVE_G);
                        req_out.cmd <= (byte_now[7:4] == QPD_OP_RECALL_G
                           || byte_now[7:4] == QPD_OP_RECALL1)
                           ? QPD_CMD_RCL : QPD_CMD_SAVE;
                        req_tgl_out <= ~req_tgl_out;
                     end
                     default: begin
                        ack_pend <= 1'b0;
                     end
                  endcase
               end
            end
            QPD_L_DATA: begin
               shreg   <= byte_now;
               bit_cnt <= bit_cnt + 3'h1;
               if (bit_cnt == 3'h7) begin
                  req_out.data <= byte_now[5:0];
                  req_out.cmd  <= (opcode == QPD_OP_WR_SLOT)
                     ? QPD_CMD_WR_SLT : QPD_CMD_WR_WIP;
                  req_tgl_out  <= ~req_tgl_out;
                  ack_pend     <= 1'b1;
                  state        <= QPD_L_SKIP;
               end
            end
            QPD_L_READ: begin
               bit_cnt <= bit_cnt + 3'h1;
               if (bit_cnt == 3'h7) begin
                  ack_pend <= 1'b1;
                  bit_cnt  <= 3'h1;
               end
            end
            QPD_L_STEP: begin
               req_out.cmd  <= QPD_CMD_STEP;
               req_out.data <= {5'h00, sda_in};
               req_tgl_out  <= ~req_tgl_out;
            end
            default: begin
            end
         endcase
      end
   end

   // drive on falling scl
   always_ff @(negedge scl_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sda_oe_out <= 1'b0;
      end else if (ack_pend
                   && (state != QPD_L_READ || bit_cnt == 3'h0)) begin
         sda_oe_out <= 1'b1;
      end else if (state == QPD_L_READ && !ack_pend) begin
         sda_oe_out <= ~tx_byte[3'h7 - bit_cnt];
      end else begin
         sda_oe_out <= 1'b0;
      end
   end
endmodule

/* File: rtl/qpd_core.sv */
`timescale 1ns/1ps
// =====================================================
// Overview of operation
// - read wiper: address, ack, opcode 1001 with pot, ack, 8 data bits out.
// - write wiper: address, opcode 1010 with pot, one data byte, each acked.
// - read setting: opcode 1011 with pot and slot; device returns one byte.
// - write setting: opcode 1100 with pot and slot, then data byte stored.
// - global recall 0001: every pot loads chosen slot into its wiper.
// - global save 1000: every pot copies wiper into chosen slot.
// - single save 1110: one pot's wiper copied into chosen slot.
// - single recall uses opcode 1101, loading chosen slot into that wiper.
// - step 0010 with pot: each following bit steps the wiper once.
// - nonvolatile programming waits until the frame's stop.
// - four 6-bit wipers and sixteen 6-bit setting slots.
// - after reset each wiper loads from its slot zero.
// - each nonvolatile change completes within 5 ms.
// - step bit high moves toward high terminal, low toward low.
module qpd_core
   import qpd_pkg::*;
#(
   parameter int NV_CYCLES = QPD_NV_CYCLES
)
(
   input  wire logic        clk_sys_in,
   input  wire logic        rst_b_in,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   input  wire logic [3:0]  strap_addr_in,
   output logic             sda_oe_out,
   output logic             sda_out,
   output logic [23:0]      wiper_position_out,
   output logic             nv_busy_out
);
   // =====================================================
   // storage
   logic [5:0]  wiper_position_register [QPD_POTS];
   logic [5:0]  stored_setting_register [QPD_POTS*QPD_SLOTS];
   logic        recalled;
   qpd_req_t    req;
   logic        req_tgl;
   logic        stop_tgl;
   logic [1:0]  rd_pot;
   logic [1:0]  rd_slot;
   logic        rd_slot_sel;
   logic [5:0]  rd_data;
   logic [2:0]  req_sync;
   logic [2:0]  stop_sync;
   logic        req_seen;
   logic        stop_seen;
   qpd_req_t    nv_req;
   logic        nv_pend;
   logic [31:0] nv_cnt;
   logic        nv_commit;

   assign sda_out = 1'b0;

   qpd_link u_link (
      .scl_in          (scl_in),
      .rst_b_in        (rst_b_in),
      .sda_in          (sda_in),
      .strap_addr_in   (strap_addr_in),
      .rd_data_in      (rd_data),
      .sda_oe_out      (sda_oe_out),
      .rd_pot_out      (rd_pot),
      .rd_slot_out     (rd_slot),
      .rd_slot_sel_out (rd_slot_sel),
      .req_out         (req),
      .req_tgl_out     (req_tgl),
      .stop_tgl_out    (stop_tgl)
   );

   // =====================================================
   // crossing: toggles synchronised, request held stable
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         req_sync  <= 3'h0;
         stop_sync <= 3'h0;
      end else begin
         req_sync  <= {req_sync[1:0], req_tgl};
         stop_sync <= {stop_sync[1:0], stop_tgl};
      end
   end
   assign req_seen  = req_sync[2] ^ req_sync[1];
   assign stop_seen = stop_sync[2] ^ stop_sync[1];

   // =====================================================
   // read data for the link, registered here; pot and slot
   // settle a full bit time before the first read bit
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_data <= 6'h00;
      end else if (rd_slot_sel) begin
         rd_data <= stored_setting_register[{rd_pot, rd_slot}];
      end else begin
         rd_data <= wiper_position_register[rd_pot];
      end
   end

   // =====================================================
   // slot change held until the frame's stop; a new request
   // wins over a stop seen in the same cycle
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         nv_req  <= '0;
         nv_pend <= 1'b0;
      end else if (req_seen && !nv_busy_out
                   && (req.cmd == QPD_CMD_WR_SLT
                       || req.cmd == QPD_CMD_SAVE)) begin
         nv_req  <= req;
         nv_pend <= 1'b1;
      end else if (nv_pend && stop_seen) begin
         nv_pend <= 1'b0;
      end
   end

   // =====================================================
   // programming cycle
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         nv_busy_out <= 1'b0;
         nv_cnt      <= 32'h0000_0000;
      end else if (nv_pend && stop_seen) begin
         nv_busy_out <= 1'b1;
         nv_cnt      <= 32'(NV_CYCLES - 1);
      end else if (nv_busy_out) begin
         if (nv_cnt == 32'h0000_0000) begin
            nv_busy_out <= 1'b0;
         end else begin
            nv_cnt <= nv_cnt - 32'h0000_0001;
         end
      end
   end
   assign nv_commit = nv_busy_out && nv_cnt == 32'h0000_0000;

   // =====================================================
   // setting slots, committed at end of programming cycle
   always_ff @(posedge clk_sys_in) begin
      for (int p = 0; p < QPD_POTS; p++) begin
         if (nv_commit) begin
            if (nv_req.cmd == QPD_CMD_WR_SLT
                && nv_req.pot == 2'(p)) begin
               stored_setting_register[{nv_req.pot, nv_req.slot}]
                  <= nv_req.data;
            end else if (nv_req.cmd == QPD_CMD_SAVE
                && (nv_req.all_pots || nv_req.pot == 2'(p))) begin
               stored_setting_register[{2'(p), nv_req.slot}]
                  <= wiper_position_register[p];
            end
         end
      end
   end

   // =====================================================
   // power-up recall runs once, first edge after reset
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         recalled <= 1'b0;
      end else begin
         recalled <= 1'b1;
      end
   end

   // =====================================================
   // wipers
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int p = 0; p < QPD_POTS; p++) begin
            wiper_position_register[p] <= QPD_WIPER_MIN;
         end
      end else if (!recalled) begin
         // slot zero into every wiper
         for (int p = 0; p < QPD_POTS; p++) begin
            wiper_position_register[p] <=
               stored_setting_register[{2'(p), 2'h0}];
         end
      end else if (req_seen) begin
         for (int p = 0; p < QPD_POTS; p++) begin
            if (req.all_pots || req.pot == 2'(p)) begin
               case (req.cmd)
                  QPD_CMD_WR_WIP: begin
                     wiper_position_register[p] <= req.data;
                  end
                  QPD_CMD_RCL: begin
                     wiper_position_register[p] <=
                        stored_setting_register[{2'(p), req.slot}];
                  end
                  QPD_CMD_STEP: begin
                     // held at the array ends, no wrap
                     if (req.data[0]) begin
                        if (wiper_position_register[p] != QPD_WIPER_MAX) begin
                           wiper_position_register[p] <=
                              wiper_position_register[p] + 6'h01;
                        end
                     end else if (wiper_position_register[p]
                                  != QPD_WIPER_MIN) begin
                        wiper_position_register[p] <=
                           wiper_position_register[p] - 6'h01;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end

   // =====================================================
   // output packing, one cycle behind the wiper registers
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wiper_position_out <= 24'h00_0000;
      end else begin
         for (int p = 0; p < QPD_POTS; p++) begin
            wiper_position_out[p*6 +: 6] <= wiper_position_register[p];
         end
      end
   end
endmodule

/* File: verif/qpd_core_checker.sv */
`timescale 1ns/1ps
// ==========================================
// bus pin and programming cycle checks
module qpd_core_checker
   import qpd_pkg::*;
#(
   parameter int NV_CYCLES = QPD_NV_CYCLES
)
(
   input wire logic        clk_sys_in,
   input wire logic        rst_b_in,
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic [3:0]  strap_addr_in,
   input wire logic        sda_oe_out,
   input wire logic        sda_out,
   input wire logic [23:0] wiper_position_out,
   input wire logic        nv_busy_out
);
   int busy_cnt;

   // length of the current programming cycle
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         busy_cnt <= 0;
      end else if (nv_busy_out) begin
         busy_cnt <= busy_cnt + 1;
      end else begin
         busy_cnt <= 0;
      end
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);

   sequence s_ack_start;
      !scl_in ##0 $rose(sda_oe_out);
   endsequence
   sequence s_stop;
      scl_in && $rose(sda_in);
   endsequence

   property p_pull_only; sda_out == 1'h0; endproperty
   property p_oe_on_low; $changed(sda_oe_out) |-> !scl_in; endproperty
   property p_oe_hold; s_ack_start |-> sda_oe_out [*5]; endproperty
   property p_stop_free; s_stop |-> !sda_oe_out; endproperty
   property p_busy_after_stop;
      $rose(nv_busy_out) |-> scl_in && sda_in && $past(scl_in);
   endproperty
   property p_busy_len; $fell(nv_busy_out) |-> busy_cnt >= NV_CYCLES - 2;
   endproperty
   property p_busy_max; nv_busy_out |-> busy_cnt <= NV_CYCLES + 4;
   endproperty
   property p_commit_keeps;
      $fell(nv_busy_out) |-> $stable(wiper_position_out);
   endproperty

   a_pull_only: assert property (p_pull_only)
      else $error("sda driven high");
   a_oe_on_low: assert property (p_oe_on_low)
      else $error("sda enable moved while scl high");
   a_oe_hold: assert property (p_oe_hold)
      else $error("sda low pulse shorter than one bit");
   a_stop_free: assert property (p_stop_free)
      else $error("sda held at stop");
   a_busy_after_stop: assert property (p_busy_after_stop)
      else $error("programming began inside a frame");
   a_busy_len: assert property (p_busy_len)
      else $error("programming cycle too short");
   a_busy_max: assert property (p_busy_max)
      else $error("programming cycle too long");
   a_commit_keeps: assert property (p_commit_keeps)
      else $error("wiper moved at commit");
endmodule

bind qpd_core qpd_core_checker #(.NV_CYCLES(NV_CYCLES)) chk_u (
   .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .scl_in(scl_in),
   .sda_in(sda_in), .strap_addr_in(strap_addr_in),
   .sda_oe_out(sda_oe_out), .sda_out(sda_out),
   .wiper_position_out(wiper_position_out), .nv_busy_out(nv_busy_out));

/* File: verif/qpd_host.sv */
`timescale 1ns/1ps
// ==========================================
// bus master model, scl idles high between frames
module qpd_host
(
   output logic      scl_out,
   output logic      sda_low_out,
   input  wire logic sda_in
);
   initial begin
      scl_out     = 1'h1;
      sda_low_out = 1'h0;
   end
   // data set mid-low, sampled mid-high, 160 ns per bit
   task automatic bit_x(input logic b, output logic r);
      #40 sda_low_out = ~b;
      #40 scl_out = 1'h1;
      #40 r = sda_in;
      #40 scl_out = 1'h0;
   endtask
   task automatic start_c();
      #40 sda_low_out = 1'h1;
      #40 scl_out = 1'h0;
   endtask
   task automatic stop_c();
      #40 sda_low_out = 1'h1;
      #40 scl_out = 1'h1;
      #40 sda_low_out = 1'h0;
      #40;
   endtask
   task automatic xbyte(input logic [7:0] d, input logic ninth,
                        output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r[i]);
      end
      bit_x(ninth, a);
   endtask
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
   import qpd_pkg::*;
   localparam int         NV    = 20;
   localparam logic [3:0] STRAP = 4'h6;
   logic        clk_sys;
   logic        rst_b;
   logic [3:0]  strap;
   logic [7:0]  rd;
   logic [7:0]  cur [4];
   wire         scl;
   wire         host_low;
   wire         oe;
   wire         sda_zero;
   wire         busy;
   wire [23:0]  wip;
   wire         sda = ~(host_low | oe);
   int          mismatches;
   int          num_checks;

   initial begin
      clk_sys = 1'h0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   qpd_core #(.NV_CYCLES(NV)) dut_u (
      .clk_sys_in(clk_sys), .rst_b_in(rst_b), .scl_in(scl), .sda_in(sda),
      .strap_addr_in(strap), .sda_oe_out(oe), .sda_out(sda_zero),
      .wiper_position_out(wip), .nv_busy_out(busy));
   qpd_host host_u (.scl_out(scl), .sda_low_out(host_low), .sda_in(sda));

   // ==========================================
   // helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   function automatic logic [7:0] wiper(input int p);
      return {2'h0, wip[6*p +: 6]};
   endfunction
   function automatic logic [7:0] slotv(input int p, input int s);
      return {2'h0, 6'(p * 13 + s * 3 + 5)};
   endfunction
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask
   // nd: 0 no data byte, 1 write byte, 2 read byte into rd
   task automatic frame(input logic [7:0] ins, input int nd,
                        input logic [7:0] wd, input logic bad);
      logic [7:0] r;
      logic       a;
      host_u.start_c();
      host_u.xbyte({QPD_DEV_CODE, bad ? ~STRAP : STRAP}, 1'h1, r, a);
      chk({7'h0, a}, {7'h0, bad}, "address ack");
      host_u.xbyte(ins, 1'h1, r, a);
      chk({7'h0, a}, {7'h0, bad}, "instr ack");
      if (nd == 1) begin
         host_u.xbyte(wd, 1'h1, r, a);
         chk({7'h0, a}, {7'h0, bad}, "data ack");
      end
      if (nd == 2) begin
         host_u.xbyte(8'hFF, 1'h1, rd, a);
      end
      chk({7'h0, busy}, 8'h0, "busy before stop");
      host_u.stop_c();
      cyc(8);
   endtask
   task automatic wait_nv();
      int n;
      chk({7'h0, busy}, 8'h1, "programming started");
      for (n = 0; n < 200 && busy !== 1'h0; n++) cyc(1);
      if (n >= 200) begin
         mismatches++;
         $display("mismatch at %0t: busy stuck", $time);
         tally_and_finish();
      end
      chk({7'h0, n <= NV}, 8'h1, "program time");
   endtask
   task automatic step_run(input int p, input logic [5:0] v0,
                           input logic [7:0] pat, input int n,
                           input logic [7:0] e);
      logic [7:0] r;
      logic       a;
      frame({4'hA, 2'(p), 2'h0}, 1, {2'h0, v0}, 1'h0);
      host_u.start_c();
      host_u.xbyte({QPD_DEV_CODE, STRAP}, 1'h1, r, a);
      host_u.xbyte({4'h2, 2'(p), 2'h0}, 1'h1, r, a);
      chk({7'h0, a}, 8'h0, "step ack");
      for (int i = n - 1; i >= 0; i--) host_u.bit_x(pat[i], a);
      cyc(4);
      chk(wiper(p), e, "step result");
      host_u.stop_c();
      cyc(8);
   endtask

   // ==========================================
   // scenarios
   task automatic t_slots();
      for (int p = 0; p < 4; p++) begin
         for (int s = 0; s < 4; s++) begin
            frame({4'hC, 2'(p), 2'(s)}, 1, slotv(p, s), 1'h0);
            wait_nv();
         end
      end
      for (int p = 0; p < 4; p++) begin
         for (int s = 0; s < 4; s++) begin
            frame({4'hB, 2'(p), 2'(s)}, 2, 8'h00, 1'h0);
            chk(rd, slotv(p, s), "slot read");
         end
      end
      $display("test slots done");
   endtask
   task automatic t_reset();
      rst_b = 1'h0;
      cyc(6);
      rst_b = 1'h1;
      cyc(6);
      for (int p = 0; p < 4; p++) chk(wiper(p), slotv(p, 0), "reload");
      $display("test reset done");
   endtask
   task automatic t_wiper();
      for (int p = 0; p < 4; p++) begin
         cur[p] = 8'(63 - p * 7);
         frame({4'hA, 2'(p), 2'h0}, 1, cur[p], 1'h0);
         chk(wiper(p), cur[p], "wiper port");
         frame({4'h9, 2'(p), 2'h0}, 2, 8'h00, 1'h0);
         chk(rd, cur[p], "wiper read");
      end
      $display("test wiper done");
   endtask
   task automatic t_xfer();
      frame({4'hE, 2'h1, 2'h2}, 0, 8'h00, 1'h0);
      wait_nv();
      frame({4'hB, 2'h1, 2'h2}, 2, 8'h00, 1'h0);
      chk(rd, cur[1], "single save");
      frame({4'hD, 2'h1, 2'h0}, 0, 8'h00, 1'h0);
      cur[1] = slotv(1, 0);
      chk(wiper(1), cur[1], "single recall");
      chk(wiper(0), cur[0], "other pot kept");
      frame({4'h8, 2'h0, 2'h3}, 0, 8'h00, 1'h0);
      wait_nv();
      for (int p = 0; p < 4; p++) begin
         frame({4'hB, 2'(p), 2'h3}, 2, 8'h00, 1'h0);
         chk(rd, cur[p], "global save");
      end
      frame({4'h1, 2'h0, 2'h1}, 0, 8'h00, 1'h0);
      for (int p = 0; p < 4; p++) chk(wiper(p), slotv(p, 1), "recall");
      $display("test transfer done");
   endtask
   task automatic t_step();
      step_run(2, 6'h3D, 8'h1E, 5, 8'h3E);
      step_run(3, 6'h02, 8'h01, 5, 8'h01);
      $display("test step done");
   endtask
   task automatic t_bad();
      logic [7:0] r;
      logic       a;
      frame({4'hA, 2'h0, 2'h0}, 1, 8'h15, 1'h1);
      chk(wiper(0), slotv(0, 1), "foreign frame");
      host_u.start_c();
      host_u.xbyte({QPD_DEV_CODE, STRAP}, 1'h1, r, a);
      host_u.xbyte(8'h30, 1'h1, r, a);
      chk({7'h0, a}, 8'h1, "unknown opcode ack");
      host_u.stop_c();
      cyc(8);
      chk(wiper(0), slotv(0, 1), "unknown opcode kept");
      $display("test address done");
   endtask

   initial begin
      rst_b      = 1'h0;
      strap      = STRAP;
      mismatches = 0;
      num_checks = 0;
      repeat (6) @(posedge clk_sys);
      #2 rst_b = 1'h1;
      cyc(6);
      t_slots();
      t_reset();
      t_wiper();
      t_xfer();
      t_step();
      t_bad();
      tally_and_finish();
   end
endmodule
